/* hdl/feiu_pkg.sv */
// constants of the flash event interrupt unit
package feiu_pkg;
  // register offsets
  localparam logic [2:0] OFF_CFG = 3'h0;
  localparam logic [2:0] OFF_STAT = 3'h1;
  localparam logic [2:0] OFF_LOG = 3'h2;
  localparam logic [2:0] OFF_MASK = 3'h3;
  // field positions
  localparam int BIT_OUT_DIS = 15;
  localparam int BIT_READY = 4;
  localparam int BIT_POR = 2;
  localparam int BIT_DBL = 1;
  localparam int BIT_SGL = 0;
  // reset values and masks
  localparam logic [15:0] CFG_RST = 16'hFFFF;
  localparam logic [15:0] CFG_RSVD = 16'h7FEC;
  localparam logic [15:0] STAT_HW_RST = 16'hFFFF;
  localparam logic [15:0] STAT_POR_RST = 16'hFFFB;
  localparam logic [15:0] STAT_NO_POR = 16'hFFFB;
  localparam logic [15:0] CHAN_MASK = 16'h0013;
  localparam logic [15:0] LOG_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
endpackage : feiu_pkg

/* hdl/feiu_evt_if.sv */
// event signals between the detector and the register core
`timescale 1ns/1ps
interface feiu_evt_if;
  logic busy;
  logic ecc_sgl;
  logic ecc_dbl;
  logic ev_ready;
  logic ev_sgl;
  logic ev_dbl;
  modport det (
    input busy,
    input ecc_sgl,
    input ecc_dbl,
    output ev_ready,
    output ev_sgl,
    output ev_dbl
  );
  modport core (
    output busy,
    output ecc_sgl,
    output ecc_dbl,
    input ev_ready,
    input ev_sgl,
    input ev_dbl
  );
endinterface : feiu_evt_if

/* hdl/feiu_evt_det.sv */
// event detector: busy-to-ready edge and ecc pulses
`timescale 1ns/1ps
module feiu_evt_det (
  input wire logic clock_i,
  input wire logic rst_i,
  feiu_evt_if.det evt
);
  logic busy_q;

  // ------------------------------------------
  // edge detection
  // ------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      evt.ev_ready <= 1'b0;
    end else begin
      busy_q <= evt.busy;
      evt.ev_ready <= busy_q & ~evt.busy;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      evt.ev_sgl <= 1'b0;
      evt.ev_dbl <= 1'b0;
    end else begin
      evt.ev_sgl <= evt.ecc_sgl;
      evt.ev_dbl <= evt.ecc_dbl;
    end
  end

  a_ready_edge: assert property (@(posedge clock_i) disable iff (rst_i)
    (busy_q && !evt.busy) |=> evt.ev_ready) // RULE_06
    else $error("ready edge not detected");
endmodule : feiu_evt_det

/* hdl/feiu_top.sv */
// top of the flash event interrupt unit
// What this block does
// RULE_01 - alert pin is open drain, low active
// RULE_02 - config bit 15 gates the alert pin
// RULE_03 - writing 1 to bit 15 clears flags
// RULE_04 - disabling a channel clears its flag
// RULE_05 - alert low until enabled flags cleared
// RULE_06 - config bit 4 enables ready channel
// RULE_07 - config bit 1 enables double-error channel
// RULE_08 - config bit 0 enables single-error channel
// RULE_09 - status bit 4 low after ready edge
// RULE_10 - status bits 1,0 low after errors
// RULE_11 - status records enabled events since clear
// RULE_12 - power-on reset clears only status bit 2
// RULE_13 - bit 2 set only by reset or write
// RULE_14 - bit 2 never affects the alert pin
// RULE_15 - hardware reset sets all status bits
// RULE_16 - both resets disable all channels
// RULE_17 - writes only raise status bits
// RULE_18 - host reads status, then clears source
// RULE_19 - alert drive equation of enables and flags
`timescale 1ns/1ps
module feiu_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic busy_i,
  input wire logic ecc_sgl_i,
  input wire logic ecc_dbl_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic alert_n_o,
  output logic alert_oe_o,
  output logic irq_o
);

  // ------------------------------------------
  // decoding
  // ------------------------------------------
  function automatic logic feiu_hit(
    input logic [2:0] a,
    input logic [2:0] off
  );
    feiu_hit = (a == off);
  endfunction : feiu_hit

  logic any_rst;
  logic cfg_wr;
  logic stat_wr;
  logic log_wr;
  logic mask_wr;
  logic [15:0] cfg;
  logic [15:0] flag;
  logic [15:0] log_q;
  logic [15:0] mask;
  logic [15:0] next_flag;
  logic [15:0] next_log;
  logic [15:0] next_mask;
  logic [15:0] ev_vec;
  logic [15:0] rec_vec;
  logic next_alert;
  logic next_irq;
  logic [15:0] next_rdata;

  assign any_rst = rst_i | por_i;
  assign cfg_wr = wr_i & feiu_hit(addr_i, feiu_pkg::OFF_CFG);
  assign stat_wr = wr_i & feiu_hit(addr_i, feiu_pkg::OFF_STAT);
  assign log_wr = wr_i & feiu_hit(addr_i, feiu_pkg::OFF_LOG);
  assign mask_wr = wr_i & feiu_hit(addr_i, feiu_pkg::OFF_MASK);

  // ------------------------------------------
  // event detection
  // ------------------------------------------
  feiu_evt_if evt ();

  assign evt.busy = busy_i;
  assign evt.ecc_sgl = ecc_sgl_i;
  assign evt.ecc_dbl = ecc_dbl_i;

  feiu_evt_det feiu_evt_det_i (
    .clock_i(clock_i),
    .rst_i(any_rst),
    .evt(evt)
  );

  always_comb begin
    ev_vec = 16'h0000;
    ev_vec[feiu_pkg::BIT_READY] = evt.ev_ready;
    ev_vec[feiu_pkg::BIT_DBL] = evt.ev_dbl;
    ev_vec[feiu_pkg::BIT_SGL] = evt.ev_sgl;
  end

  // only events of enabled channels are recorded in the status flags
  assign rec_vec = ev_vec & ~cfg & feiu_pkg::CHAN_MASK; // RULE_11 RULE_06 RULE_07 RULE_08

  // ------------------------------------------
  // configuration register
  // ------------------------------------------
  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      cfg <= feiu_pkg::CFG_RST; // RULE_16
    end else if (cfg_wr) begin
      cfg <= wdata_i | feiu_pkg::CFG_RSVD;
    end
  end

  // ------------------------------------------
  // status flags, active low
  // ------------------------------------------
  always_comb begin
    next_flag = flag;
    if (stat_wr) begin
      next_flag = next_flag | wdata_i; // RULE_17
    end
    if (cfg_wr && wdata_i[feiu_pkg::BIT_OUT_DIS]) begin
      next_flag = next_flag | feiu_pkg::STAT_NO_POR; // RULE_03
    end
    if (cfg_wr) begin
      next_flag = next_flag | (wdata_i & feiu_pkg::CHAN_MASK); // RULE_04
    end
    // a recorded event wins over any clear in the same cycle
    next_flag = next_flag & ~rec_vec; // RULE_09 RULE_10
  end

  always_ff @(posedge clock_i) begin
    if (por_i) begin
      flag <= feiu_pkg::STAT_POR_RST; // RULE_12
    end else if (rst_i) begin
      flag <= feiu_pkg::STAT_HW_RST; // RULE_15 RULE_13
    end else begin
      flag <= next_flag;
    end
  end

  // ------------------------------------------
  // alert pin
  // ------------------------------------------
  // bit 2 is left out of the term on purpose
  assign next_alert = ~cfg[feiu_pkg::BIT_OUT_DIS] &
    (|(~flag & ~cfg & feiu_pkg::CHAN_MASK)); // RULE_19 RULE_05 RULE_14 RULE_02

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      alert_oe_o <= 1'b0; // RULE_16
    end else begin
      alert_oe_o <= next_alert; // RULE_01
    end
  end

  // open drain: only ever drives low
  always_ff @(posedge clock_i) begin
    alert_n_o <= 1'b0; // RULE_01
  end

  // ------------------------------------------
  // event log and interrupt line
  // ------------------------------------------
  always_comb begin
    next_log = log_q;
    if (log_wr) begin
      next_log = next_log & ~wdata_i;
    end
    next_log = next_log | ev_vec;
  end

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      log_q <= feiu_pkg::LOG_RST;
    end else begin
      log_q <= next_log;
    end
  end

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      mask <= feiu_pkg::MASK_RST;
    end else if (mask_wr) begin
      mask <= wdata_i & feiu_pkg::CHAN_MASK;
    end
  end

  // mask as it stands after this edge, so the line never lags a mask write
  always_comb begin
    next_mask = mask;
    if (mask_wr) begin
      next_mask = wdata_i & feiu_pkg::CHAN_MASK;
    end
  end

  assign next_irq = |(next_log & next_mask);

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // ------------------------------------------
  // read port
  // ------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        feiu_pkg::OFF_CFG: next_rdata = cfg;
        feiu_pkg::OFF_STAT: next_rdata = flag; // RULE_18
        feiu_pkg::OFF_LOG: next_rdata = log_q;
        feiu_pkg::OFF_MASK: next_rdata = mask;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ------------------------------------------
  // assertions
  // ------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (any_rst);

  a_pin_low_only: assert property ( // RULE_01
    !alert_n_o)
    else $error("alert pin drives high");

  a_gate_off: assert property ( // RULE_02
    cfg[feiu_pkg::BIT_OUT_DIS] |=> !alert_oe_o)
    else $error("alert driven while output disabled");

  a_out_dis_clr: assert property ( // RULE_03
    (cfg_wr && wdata_i[feiu_pkg::BIT_OUT_DIS] && !(|ev_vec))
    |=> (flag[feiu_pkg::BIT_READY] && flag[feiu_pkg::BIT_DBL]
         && flag[feiu_pkg::BIT_SGL]))
    else $error("flags not cleared by output disable");

  a_chan_clr: assert property ( // RULE_04
    (cfg_wr && wdata_i[feiu_pkg::BIT_SGL] && !evt.ev_sgl)
    |=> flag[feiu_pkg::BIT_SGL])
    else $error("single flag not cleared on channel disable");

  a_alert_hold: assert property ( // RULE_05
    (!cfg[feiu_pkg::BIT_OUT_DIS] && !cfg[feiu_pkg::BIT_DBL]
     && !flag[feiu_pkg::BIT_DBL] && !cfg_wr) |=> alert_oe_o)
    else $error("alert released with enabled flag low");

  a_ready_rec: assert property ( // RULE_06
    (evt.ev_ready && !cfg[feiu_pkg::BIT_READY]
     && !cfg[feiu_pkg::BIT_OUT_DIS] && !cfg_wr)
    |=> !flag[feiu_pkg::BIT_READY] ##1 alert_oe_o)
    else $error("ready event did not reach the pin");

  a_dbl_rec: assert property ( // RULE_07
    (evt.ev_dbl && !cfg[feiu_pkg::BIT_DBL]) |=> !flag[feiu_pkg::BIT_DBL])
    else $error("double error not recorded");

  a_sgl_rec: assert property ( // RULE_08
    (evt.ev_sgl && !cfg[feiu_pkg::BIT_SGL]) |=> !flag[feiu_pkg::BIT_SGL])
    else $error("single error not recorded");

  a_ready_ign: assert property ( // RULE_09
    (cfg[feiu_pkg::BIT_READY] && flag[feiu_pkg::BIT_READY] && !stat_wr)
    |=> flag[feiu_pkg::BIT_READY])
    else $error("disabled ready channel recorded");

  a_flag_idle: assert property ( // RULE_10
    (flag[feiu_pkg::BIT_DBL] && !evt.ev_dbl) |=> flag[feiu_pkg::BIT_DBL])
    else $error("double flag fell without event");

  a_por_set: assert property ( // RULE_13
    ($rose(flag[feiu_pkg::BIT_POR]) && !$past(any_rst))
    |-> $past(stat_wr && wdata_i[feiu_pkg::BIT_POR]))
    else $error("por bit set without write");

  a_por_blind: assert property ( // RULE_14
    (!flag[feiu_pkg::BIT_POR] && (&(flag | ~feiu_pkg::CHAN_MASK))
     && !(|ev_vec)) |=> ##1 !alert_oe_o)
    else $error("por bit moved the alert pin");

  a_no_fall: assert property ( // RULE_17
    $fell(flag[feiu_pkg::BIT_SGL]) |-> $past(evt.ev_sgl))
    else $error("status bit fell without event");

  a_hw_rst: assert property (@(posedge clock_i) disable iff (1'b0) // RULE_15
    (rst_i && !por_i) |=> (flag == feiu_pkg::STAT_HW_RST
      && cfg == feiu_pkg::CFG_RST && !alert_oe_o))
    else $error("hardware reset values wrong");

  a_por_rst: assert property (@(posedge clock_i) disable iff (1'b0) // RULE_12
    por_i |=> (flag == feiu_pkg::STAT_POR_RST
      && cfg == feiu_pkg::CFG_RST && !alert_oe_o)) // RULE_16
    else $error("power-on reset values wrong");

  a_irq_level: assert property (
    (|(log_q & mask)) |-> irq_o)
    else $error("interrupt line low with pending log");

  a_irq_clear: assert property (
    !(|(log_q & mask)) |-> !irq_o)
    else $error("interrupt line high with nothing pending");

  a_ready_clr: assert property ( // RULE_04
    (cfg_wr && wdata_i[feiu_pkg::BIT_READY] && !evt.ev_ready)
    |=> flag[feiu_pkg::BIT_READY])
    else $error("ready flag not cleared on channel disable");

  a_dbl_clr: assert property ( // RULE_04
    (cfg_wr && wdata_i[feiu_pkg::BIT_DBL] && !evt.ev_dbl)
    |=> flag[feiu_pkg::BIT_DBL])
    else $error("double flag not cleared on channel disable");

  a_sgl_hold: assert property ( // RULE_05
    (!cfg[feiu_pkg::BIT_OUT_DIS] && !cfg[feiu_pkg::BIT_SGL]
     && !flag[feiu_pkg::BIT_SGL]) |=> alert_oe_o)
    else $error("alert released with single flag low");

  a_stat_rsvd: assert property ( // RULE_17
    &(flag | feiu_pkg::CHAN_MASK | ~feiu_pkg::STAT_NO_POR))
    else $error("reserved status bit fell");

  a_rdata_idle: assert property (
    !rd_i |=> (rdata_o == 16'h0000))
    else $error("read data outside a read cycle");

  c_ready_alert: cover property (
    evt.ev_ready && !cfg[feiu_pkg::BIT_READY] ##2 alert_oe_o);

  c_out_dis: cover property (
    alert_oe_o ##0 (cfg_wr && wdata_i[feiu_pkg::BIT_OUT_DIS]) ##2 !alert_oe_o);

  c_por_clear: cover property (
    !flag[feiu_pkg::BIT_POR] ##1 stat_wr ##1 flag[feiu_pkg::BIT_POR]);

  c_irq: cover property (
    !irq_o ##1 irq_o);

endmodule : feiu_top

/* verification/feiu_host_model.sv */
// host side model: pull-up on the alert wire and alert watcher
`timescale 1ns/1ps
module feiu_host_model (
  input wire logic clock_i,
  input wire logic alert_n_i,
  input wire logic alert_oe_i,
  output logic alert_pin_o,
  output logic alert_seen_o
);
  // released wire floats up through the pull-up
  assign alert_pin_o = alert_oe_i ? alert_n_i : 1'b1;
  initial alert_seen_o = 1'b0;
  // remembers a low alert from then on; nothing ever clears it
  always @(posedge clock_i) begin
    if (alert_pin_o === 1'b0) begin
      alert_seen_o <= 1'b1;
    end
  end
endmodule : feiu_host_model

/* verification/flash_event_interrupt_unit_test.sv */
// self-checking bench of the flash event interrupt unit
`timescale 1ns/1ps
module flash_event_interrupt_unit_test;
  logic clock_i, rst_i, por_i, busy_i, ecc_sgl_i, ecc_dbl_i, wr_i, rd_i, rd_q;
  logic [2:0] addr_i;
  logic [15:0] wdata_i, rdata_o, lfsr, v;
  logic alert_n_o, alert_oe_o, irq_o, pin, seen;
  logic [15:0] exp_q[$];
  int err_total, num_checks;
  feiu_top feiu_top_i (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i), .busy_i(busy_i),
    .ecc_sgl_i(ecc_sgl_i), .ecc_dbl_i(ecc_dbl_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .alert_n_o(alert_n_o),
    .alert_oe_o(alert_oe_o), .irq_o(irq_o));
  feiu_host_model feiu_host_model_i (.clock_i(clock_i), .alert_n_i(alert_n_o),
    .alert_oe_i(alert_oe_o), .alert_pin_o(pin), .alert_seen_o(seen));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d errors=%0d queued=%0d", num_checks, err_total, exp_q.size());
    if (err_total == 0 && num_checks > 0 && exp_q.size() == 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    if (r) begin
      exp_q.push_back(d);
    end
    @(posedge clock_i);
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] d);
    bus(1'b0, 1'b1, a, d);
  endtask : rd
  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask : idle
  // one event of channel c (0 ready, 1 double, 2 single), then settle
  task automatic fire(input int c);
    idle(0);
    busy_i <= (c == 0);
    ecc_dbl_i <= (c == 1);
    ecc_sgl_i <= (c == 2);
    @(posedge clock_i);
    busy_i <= 1'b0;
    ecc_dbl_i <= 1'b0;
    ecc_sgl_i <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : fire
  task automatic pin_is(input logic b);
    chk({15'h0000, pin}, {15'h0000, b});
  endtask : pin_is
  task automatic irq_is(input logic b);
    chk({15'h0000, irq_o}, {15'h0000, b});
  endtask : irq_is
  // ----------------------------------------
  // clock, read monitor, watchdog
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (rd_q === 1'b1) begin
      chk(rdata_o, exp_q.pop_front());
    end
    rd_q <= rd_i;
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    end_of_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] b[3];
    b = '{16'h0010, 16'h0002, 16'h0001};
    {rst_i, por_i, busy_i, ecc_sgl_i, ecc_dbl_i, wr_i, rd_i} = 7'h40;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    lfsr = 16'h9EFD;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    idle(1);
    rd(feiu_pkg::OFF_CFG, 16'hFFFF);
    rd(feiu_pkg::OFF_STAT, 16'hFFFF);
    idle(1);
    pin_is(1'b1);
    por_i <= 1'b1;
    idle(1);
    por_i <= 1'b0;
    idle(1);
    rd(feiu_pkg::OFF_STAT, 16'hFFFB);
    wr(feiu_pkg::OFF_CFG, 16'h0000);
    rd(feiu_pkg::OFF_CFG, 16'h7FEC);
    idle(4);
    pin_is(1'b1);
    wr(feiu_pkg::OFF_STAT, 16'h0004);
    rd(feiu_pkg::OFF_STAT, 16'hFFFF);
    for (int c = 0; c < 3; c++) begin
      fire(c);
      rd(feiu_pkg::OFF_STAT, ~b[c]);
      pin_is(1'b0);
      wr(feiu_pkg::OFF_STAT, 16'h0000);
      rd(feiu_pkg::OFF_STAT, ~b[c]);
      wr(feiu_pkg::OFF_STAT, b[c]);
      idle(3);
      pin_is(1'b1);
    end
    fire(0);
    fire(2);
    wr(feiu_pkg::OFF_STAT, 16'h0010);
    idle(3);
    pin_is(1'b0);
    wr(feiu_pkg::OFF_CFG, 16'h0001);
    rd(feiu_pkg::OFF_STAT, 16'hFFFF);
    idle(3);
    pin_is(1'b1);
    fire(2);
    rd(feiu_pkg::OFF_STAT, 16'hFFFF);
    pin_is(1'b1);
    fire(1);
    pin_is(1'b0);
    wr(feiu_pkg::OFF_CFG, 16'h8000);
    rd(feiu_pkg::OFF_STAT, 16'hFFFF);
    fire(0);
    rd(feiu_pkg::OFF_STAT, 16'hFFEF);
    pin_is(1'b1);
    wr(feiu_pkg::OFF_CFG, 16'h0000);
    idle(4);
    pin_is(1'b0);
    chk({15'h0000, seen}, 16'h0001);
    wr(feiu_pkg::OFF_MASK, 16'h0013);
    rd(feiu_pkg::OFF_MASK, 16'h0013);
    rd(feiu_pkg::OFF_LOG, 16'h0013);
    idle(2);
    irq_is(1'b1);
    wr(feiu_pkg::OFF_LOG, 16'h0013);
    idle(2);
    irq_is(1'b0);
    fire(2);
    irq_is(1'b1);
    wr(feiu_pkg::OFF_MASK, 16'h0000);
    idle(2);
    irq_is(1'b0);
    wr(3'h5, 16'hFFFF);
    rd(3'h5, 16'h0000);
    rd(feiu_pkg::OFF_CFG, 16'h7FEC);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      v = lfsr;
      wr(feiu_pkg::OFF_CFG, v);
      rd(feiu_pkg::OFF_CFG, v | feiu_pkg::CFG_RSVD);
    end
    por_i <= 1'b1;
    idle(1);
    por_i <= 1'b0;
    rst_i <= 1'b1;
    idle(1);
    rst_i <= 1'b0;
    idle(1);
    rd(feiu_pkg::OFF_STAT, 16'hFFFF);
    rd(feiu_pkg::OFF_CFG, 16'hFFFF);
    pin_is(1'b1);
    idle(3);
    end_of_test();
  end
endmodule : flash_event_interrupt_unit_test
